// *** rtl/fault_sup_params.svh ***
// constants of the dual buck fault supervisor: offsets, field positions, reset values, timing
// assumes inclusion by the package and by the supervisor top; definitions only
//
// Operation
// - overvoltage on either output latches fault, drops both power-ok, clamps both low sides
// - each undervoltage monitor arms only 4096 oscillator cycles after its enable
// - armed undervoltage latches fault, drops power-ok, discharges both channels
// - after discharge reaches the clamp level, turn the low-side gate on
// - over-temperature latches fault, drops power-ok, discharges both channels
// - thermal fault clears only once temperature flag dropped; user toggles an enable
// - fault latch holds until an enable toggles or power-on reset
// - any select input transition forces main channel PWM for strap-chosen time
// - strap supply 150us, open 100us, reference 50us, ground no blanking 100us PWM
// - while blanking, ignore main faults and release main power-ok unless a fault is latched
// - only main channel protection is blanked, and only when blanking enabled
// - power-on reset clears the fault latch and soft-start counters
// - power-ok low in shutdown and soft-start, then released while inside window
// - discharge mode stops PWM, holds low side off, discharges to clamp level
`ifndef FAULT_SUP_PARAMS_SVH
`define FAULT_SUP_PARAMS_SVH

// ==========================================================
// timing
`define CORE_CLK_MHZ 125
`define US_TO_CYC(us) ((us) * `CORE_CLK_MHZ)
`define BLANK_LONG_US 150
`define BLANK_MID_US 100
`define BLANK_SHORT_US 50
`define BLANK_W 15
`define ARM_W 13
`define UV_ARM_OSC_CYC 13'h1000
`define SS_W 10
`define SS_OSC_CYC 10'h200
`define STRAP_SETTLE 2'h3

// ==========================================================
// strap codes from the four-level front end
`define STRAP_GND 2'h0
`define STRAP_REF 2'h1
`define STRAP_OPEN 2'h2
`define STRAP_VCC 2'h3

// ==========================================================
// register map and fields
`define ADDR_W 12
`define OFS_STATUS 12'h000
`define OFS_MASK 12'h004
`define OFS_STATE 12'h008
`define STAT_W 7
`define ST_OV_MAIN 0
`define ST_OV_AUX 1
`define ST_UV_MAIN 2
`define ST_UV_AUX 3
`define ST_THERMAL 4
`define ST_VSEL 5
`define ST_RESTART 6
`define MASK_RST 7'h00
`define STATE_W 13

`endif

// *** rtl/fault_sup_pkg.sv ***
// types of the dual buck fault supervisor
// assumes fault_sup_params.svh is on the include path
package fault_sup_pkg;
`include "fault_sup_params.svh"

    typedef enum logic [1:0] {CAUSE_NONE, CAUSE_OV, CAUSE_UV, CAUSE_OT} fault_cause_t;

    // index 0 is the main channel, index 1 the auxiliary channel
    typedef struct packed {
        logic [1:0] strap;
        logic [1:0] vsel;
        logic osc_tick;
        logic over_temp;
        logic [1:0] clamp;
        logic [1:0] in_window;
        logic [1:0] undervoltage_trip;
        logic [1:0] overvoltage_trip;
        logic [1:0] enable;
    } pin_in_t;

    typedef struct packed {
        logic pwm_run;
        logic high_side_gate_off;
        logic low_side_gate_on;
        logic low_side_gate_off;
        logic discharge;
    } chan_drive_t;

    typedef struct packed {
        logic latched;
        fault_cause_t cause;
        logic [1:0] en_prev;
        logic [1:0] vsel_prev;
        logic tick_prev;
        logic [1:0][`ARM_W-1:0] arm_cnt;
        logic [1:0][`SS_W-1:0] ss_cnt;
        logic [`BLANK_W-1:0] blank_cnt;
        logic [`BLANK_W-1:0] fpwm_cnt;
        logic [1:0] strap;
        logic [1:0] strap_wait;
        logic [`STAT_W-1:0] status;
        logic [`STAT_W-1:0] mask;
        logic [31:0] prdata;
    } sup_state_t;

endpackage

// *** rtl/fault_supervisor.sv ***
// fault latch, undervoltage arming, select blanking and power-ok logic of a dual buck
// controller, with an APB register slave and one level interrupt
// assumes comparator, strap and oscillator signals arrive as asynchronous pins
`timescale 1ns/1ps
`include "fault_sup_params.svh"
module fault_supervisor #(
    parameter logic [`BLANK_W-1:0] BLANK_LONG_CYC = `BLANK_W'(`US_TO_CYC(`BLANK_LONG_US)),
    parameter logic [`BLANK_W-1:0] BLANK_MID_CYC = `BLANK_W'(`US_TO_CYC(`BLANK_MID_US)),
    parameter logic [`BLANK_W-1:0] BLANK_SHORT_CYC = `BLANK_W'(`US_TO_CYC(`BLANK_SHORT_US))
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // asynchronous pins
    input wire logic ENABLE_MAIN,
    input wire logic ENABLE_AUX,
    input wire logic OVERVOLTAGE_TRIP_MAIN,
    input wire logic OVERVOLTAGE_TRIP_AUX,
    input wire logic UNDERVOLTAGE_TRIP_MAIN,
    input wire logic UNDERVOLTAGE_TRIP_AUX,
    input wire logic IN_WINDOW_MAIN,
    input wire logic IN_WINDOW_AUX,
    input wire logic CLAMP_LEVEL_MAIN,
    input wire logic CLAMP_LEVEL_AUX,
    input wire logic OVER_TEMP,
    input wire logic OSC_TICK,
    input wire logic VSEL_BIT0,
    input wire logic VSEL_BIT1,
    input wire logic [1:0] BLANK_TIME_STRAP,
    // channel drive
    output fault_sup_pkg::chan_drive_t DRIVE_MAIN,
    output fault_sup_pkg::chan_drive_t DRIVE_AUX,
    output logic FORCED_PWM,
    // open-drain power-ok pins
    output logic POWER_OK_MAIN_O,
    output logic POWER_OK_MAIN_OE,
    output logic POWER_OK_AUX_O,
    output logic POWER_OK_AUX_OE,
    // interrupt
    output logic IRQ,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [`ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);
    // ==========================================================
    // pin synchronisation
    fault_sup_pkg::pin_in_t p;
    fault_sup_pkg::sup_state_t s;
    fault_sup_pkg::sup_state_t next_s;

    pin_sync #(
        .W($bits(fault_sup_pkg::pin_in_t))
    ) u_sync (
        .CORE_CLK(CORE_CLK),
        .RST_N(RST_N),
        .PIN_IN({BLANK_TIME_STRAP, VSEL_BIT1, VSEL_BIT0, OSC_TICK, OVER_TEMP,
                 CLAMP_LEVEL_AUX, CLAMP_LEVEL_MAIN, IN_WINDOW_AUX, IN_WINDOW_MAIN,
                 UNDERVOLTAGE_TRIP_AUX, UNDERVOLTAGE_TRIP_MAIN,
                 OVERVOLTAGE_TRIP_AUX, OVERVOLTAGE_TRIP_MAIN, ENABLE_AUX, ENABLE_MAIN}),
        .PIN_SYNC(p)
    );

    // ==========================================================
    // derived conditions
    logic [1:0] active;
    logic [1:0] armed;
    logic [1:0] ss_done;
    logic blanking;
    logic tick;
    logic en_toggle;
    logic vsel_change;
    logic ov_hit;
    logic uv_hit;
    logic [`BLANK_W-1:0] fpwm_load;
    logic [`BLANK_W-1:0] blank_load;
    logic access;
    logic map_hit;
    logic rd_status;
    logic [`STAT_W-1:0] events;
    logic [`STAT_W-1:0] read_clear;
    logic [31:0] rdata;
    fault_sup_pkg::chan_drive_t [1:0] drv;
    logic [1:0] pg_low;

    assign tick = p.osc_tick & ~s.tick_prev;
    assign en_toggle = |(p.enable ^ s.en_prev);
    assign vsel_change = |(p.vsel ^ s.vsel_prev);
    assign blanking = s.blank_cnt != '0;

    // strap decode; ground keeps forced PWM but gives no blanking
    assign fpwm_load = (s.strap == `STRAP_VCC) ? BLANK_LONG_CYC :
                       (s.strap == `STRAP_REF) ? BLANK_SHORT_CYC : BLANK_MID_CYC;
    assign blank_load = (s.strap == `STRAP_GND) ? '0 : fpwm_load;

    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_chan
            assign active[c] = p.enable[c] & ~s.latched;
            assign armed[c] = s.arm_cnt[c] == `UV_ARM_OSC_CYC;
            assign ss_done[c] = s.ss_cnt[c] == `SS_OSC_CYC;
            always_comb begin
                drv[c] = '0;
                if (s.latched && s.cause == fault_sup_pkg::CAUSE_OV) begin
                    drv[c].high_side_gate_off = 1'b1;
                    drv[c].low_side_gate_on = 1'b1;
                end else if (!active[c]) begin
                    drv[c].high_side_gate_off = 1'b1;
                    drv[c].discharge = ~p.clamp[c];
                    drv[c].low_side_gate_off = ~p.clamp[c];
                    drv[c].low_side_gate_on = p.clamp[c];
                end else begin
                    drv[c].pwm_run = 1'b1;
                end
            end
            // power-ok pulled low unless settled inside its window
            assign pg_low[c] = s.latched | ~(active[c] & ss_done[c] & p.in_window[c]);
        end
    endgenerate

    // auxiliary protection is never blanked
    assign ov_hit = (p.overvoltage_trip[0] & active[0] & ~blanking) |
                    (p.overvoltage_trip[1] & active[1]);
    assign uv_hit = (p.undervoltage_trip[0] & armed[0] & ~blanking) |
                    (p.undervoltage_trip[1] & armed[1]);

    // ==========================================================
    // register bus decode
    assign access = PSEL & PENABLE;
    assign map_hit = (PADDR == `OFS_STATUS) | (PADDR == `OFS_MASK) | (PADDR == `OFS_STATE);
    assign rd_status = access & ~PWRITE & (PADDR == `OFS_STATUS);
    assign read_clear = rd_status ? s.prdata[`STAT_W-1:0] : '0;

    always_comb begin
        rdata = '0;
        unique case (PADDR)
            `OFS_STATUS: rdata[`STAT_W-1:0] = s.status;
            `OFS_MASK: rdata[`STAT_W-1:0] = s.mask;
            `OFS_STATE: rdata[`STATE_W-1:0] = {p.enable, s.strap, FORCED_PWM, blanking,
                                               ss_done, armed, s.cause, s.latched};
            default: rdata = '0;
        endcase
    end

    // ==========================================================
    // next state
    always_comb begin
        next_s = s;
        events = '0;
        next_s.tick_prev = p.osc_tick;
        next_s.en_prev = p.enable;
        next_s.vsel_prev = p.vsel;

        // strap is caught once, after the synchroniser has filled
        if (s.strap_wait != `STRAP_SETTLE) begin
            next_s.strap_wait = s.strap_wait + 2'h1;
            next_s.strap = p.strap;
        end

        // a new transition reloads both timers to full length
        if (vsel_change) begin
            next_s.fpwm_cnt = fpwm_load;
            next_s.blank_cnt = blank_load;
            events[`ST_VSEL] = 1'b1;
        end else begin
            if (s.fpwm_cnt != '0) begin
                next_s.fpwm_cnt = s.fpwm_cnt - `BLANK_W'(1);
            end
            if (blanking) begin
                next_s.blank_cnt = s.blank_cnt - `BLANK_W'(1);
            end
        end

        // counters run on oscillator ticks and are cleared in shutdown
        for (int i = 0; i < 2; i++) begin
            if (!active[i]) begin
                next_s.arm_cnt[i] = '0;
                next_s.ss_cnt[i] = '0;
            end else if (tick) begin
                if (!armed[i]) begin
                    next_s.arm_cnt[i] = s.arm_cnt[i] + `ARM_W'(1);
                end
                if (!ss_done[i]) begin
                    next_s.ss_cnt[i] = s.ss_cnt[i] + `SS_W'(1);
                end
            end
        end

        // overvoltage outranks the discharge faults since it clamps at once
        if (!s.latched && (ov_hit || uv_hit || p.over_temp)) begin
            next_s.latched = 1'b1;
            if (ov_hit) begin
                next_s.cause = fault_sup_pkg::CAUSE_OV;
            end else if (uv_hit) begin
                next_s.cause = fault_sup_pkg::CAUSE_UV;
            end else begin
                next_s.cause = fault_sup_pkg::CAUSE_OT;
            end
            events[`ST_OV_MAIN] = p.overvoltage_trip[0] & active[0] & ~blanking;
            events[`ST_OV_AUX] = p.overvoltage_trip[1] & active[1];
            events[`ST_UV_MAIN] = p.undervoltage_trip[0] & armed[0] & ~blanking;
            events[`ST_UV_AUX] = p.undervoltage_trip[1] & armed[1];
            events[`ST_THERMAL] = p.over_temp;
        end else if (s.latched && en_toggle && !p.over_temp) begin
            // a hot die keeps the latch; the toggle must come after it cools
            next_s.latched = 1'b0;
            next_s.cause = fault_sup_pkg::CAUSE_NONE;
            events[`ST_RESTART] = 1'b1;
        end

        // only bits shown by this read are cleared; a new event still lands
        next_s.status = (s.status & ~read_clear) | events;

        if (PSEL && !PENABLE) begin
            next_s.prdata = rdata;
        end
        if (access && PWRITE && PADDR == `OFS_MASK) begin
            next_s.mask = PWDATA[`STAT_W-1:0];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            s <= '0;
            s.mask <= `MASK_RST;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // outputs
    assign DRIVE_MAIN = drv[0];
    assign DRIVE_AUX = drv[1];
    assign FORCED_PWM = (s.fpwm_cnt != '0) & active[0];
    assign POWER_OK_MAIN_O = 1'b0;
    assign POWER_OK_AUX_O = 1'b0;
    // blanking releases main power-ok, but a latched fault still pulls it low
    assign POWER_OK_MAIN_OE = s.latched | (pg_low[0] & ~blanking);
    assign POWER_OK_AUX_OE = pg_low[1];
    assign IRQ = |(s.status & s.mask);
    assign PRDATA = s.prdata;
    assign PREADY = 1'b1;
    assign PSLVERR = access & ~map_hit;

    // ==========================================================
    // checks
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);

    a_ov_clamp: assert property (
        s.latched && s.cause == fault_sup_pkg::CAUSE_OV |->
            DRIVE_MAIN.low_side_gate_on && DRIVE_AUX.low_side_gate_on &&
            DRIVE_MAIN.high_side_gate_off && !DRIVE_AUX.pwm_run &&
            POWER_OK_MAIN_OE && POWER_OK_AUX_OE)
        else $error("overvoltage latch without clamp");

    a_uv_unarmed: assert property (
        !s.latched && !armed[0] && !armed[1] |=> s.cause != fault_sup_pkg::CAUSE_UV)
        else $error("undervoltage latched before arming");

    a_uv_latch: assert property (
        !s.latched && armed[1] && p.undervoltage_trip[1] && !ov_hit |=>
            s.latched && s.cause == fault_sup_pkg::CAUSE_UV && DRIVE_MAIN.high_side_gate_off)
        else $error("armed undervoltage not latched");

    a_clamp_on: assert property (
        s.latched && s.cause == fault_sup_pkg::CAUSE_UV && p.clamp[0] |->
            DRIVE_MAIN.low_side_gate_on && !DRIVE_MAIN.discharge)
        else $error("clamp level reached but low side off");

    a_thermal_trip: assert property (
        !s.latched && p.over_temp |=> s.latched ##0 POWER_OK_MAIN_OE && POWER_OK_AUX_OE)
        else $error("thermal fault not latched");

    a_hot_hold: assert property (
        s.latched && p.over_temp |=> s.latched)
        else $error("latch cleared while hot");

    a_latch_keep: assert property (
        s.latched && !en_toggle |=> s.latched && $stable(s.cause))
        else $error("latch lost without toggle");

    a_fpwm_start: assert property (
        vsel_change && s.strap == `STRAP_VCC |=> s.fpwm_cnt == BLANK_LONG_CYC)
        else $error("forced PWM timer not loaded");

    a_blank_release: assert property (
        blanking && !s.latched |-> !POWER_OK_MAIN_OE)
        else $error("main power-ok pulled low while blanked");

    a_gnd_noblank: assert property (
        vsel_change && s.strap == `STRAP_GND |=> !blanking && s.fpwm_cnt == BLANK_MID_CYC)
        else $error("ground strap blanked faults");

    a_reset_clear: assert property (
        $rose(RST_N) |-> !s.latched && s.ss_cnt == '0)
        else $error("reset left fault state");

    a_pg_soft: assert property (
        !ss_done[1] |-> POWER_OK_AUX_OE)
        else $error("aux power-ok released during soft-start");

    a_discharge_mode: assert property (
        DRIVE_AUX.discharge |-> DRIVE_AUX.low_side_gate_off && !DRIVE_AUX.pwm_run &&
            !p.clamp[1])
        else $error("discharge with low side on");

    a_restart_timer: assert property (
        s.fpwm_cnt != '0 && vsel_change && s.strap == `STRAP_VCC |=>
            s.fpwm_cnt == BLANK_LONG_CYC)
        else $error("timer not restarted");
endmodule

// *** rtl/pin_sync.sv ***
// two-stage synchroniser for a bundle of asynchronous pins
// assumes a single clock and synchronous active-low reset
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // pins in and synchronised copy out
    input wire logic [W-1:0] PIN_IN,
    output logic [W-1:0] PIN_SYNC
);
    logic [W-1:0] first;

    // first stage feeds only the second stage
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            first <= '0;
            PIN_SYNC <= '0;
        end else begin
            first <= PIN_IN;
            PIN_SYNC <= first;
        end
    end
endmodule

// *** test/tb.sv ***
// ==========================================================
// self-checking bench for the dual buck fault supervisor
// assumes the rtl package is compiled first; the bench drives every pin and the apb bus
`timescale 1ns/1ps
`include "fault_sup_params.svh"
module tb;
    // ==========================================================
    // signals
    localparam logic [14:0] BL = 15'h001E;
    localparam logic [14:0] BM = 15'h0014;
    localparam logic [14:0] BS = 15'h000A;
    logic CORE_CLK, RST_N, ENABLE_MAIN, ENABLE_AUX, OVERVOLTAGE_TRIP_MAIN, OVERVOLTAGE_TRIP_AUX;
    logic UNDERVOLTAGE_TRIP_MAIN, UNDERVOLTAGE_TRIP_AUX, IN_WINDOW_MAIN, IN_WINDOW_AUX;
    logic CLAMP_LEVEL_MAIN, CLAMP_LEVEL_AUX, OVER_TEMP, OSC_TICK, VSEL_BIT0, VSEL_BIT1;
    logic [1:0] BLANK_TIME_STRAP;
    fault_sup_pkg::chan_drive_t DRIVE_MAIN, DRIVE_AUX;
    logic FORCED_PWM, POWER_OK_MAIN_O, POWER_OK_MAIN_OE, POWER_OK_AUX_O, POWER_OK_AUX_OE, IRQ;
    logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rdata;
    logic rerr;
    logic [1:0] tdiv;
    int n_fail, num_checks, nf, nb;

    fault_supervisor #(.BLANK_LONG_CYC(BL), .BLANK_MID_CYC(BM), .BLANK_SHORT_CYC(BS))
    fault_supervisor_i (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .ENABLE_MAIN(ENABLE_MAIN),
        .ENABLE_AUX(ENABLE_AUX), .OVERVOLTAGE_TRIP_MAIN(OVERVOLTAGE_TRIP_MAIN),
        .OVERVOLTAGE_TRIP_AUX(OVERVOLTAGE_TRIP_AUX), .UNDERVOLTAGE_TRIP_MAIN(UNDERVOLTAGE_TRIP_MAIN),
        .UNDERVOLTAGE_TRIP_AUX(UNDERVOLTAGE_TRIP_AUX), .IN_WINDOW_MAIN(IN_WINDOW_MAIN),
        .IN_WINDOW_AUX(IN_WINDOW_AUX), .CLAMP_LEVEL_MAIN(CLAMP_LEVEL_MAIN),
        .CLAMP_LEVEL_AUX(CLAMP_LEVEL_AUX), .OVER_TEMP(OVER_TEMP), .OSC_TICK(OSC_TICK),
        .VSEL_BIT0(VSEL_BIT0), .VSEL_BIT1(VSEL_BIT1), .BLANK_TIME_STRAP(BLANK_TIME_STRAP),
        .DRIVE_MAIN(DRIVE_MAIN), .DRIVE_AUX(DRIVE_AUX), .FORCED_PWM(FORCED_PWM),
        .POWER_OK_MAIN_O(POWER_OK_MAIN_O), .POWER_OK_MAIN_OE(POWER_OK_MAIN_OE),
        .POWER_OK_AUX_O(POWER_OK_AUX_O), .POWER_OK_AUX_OE(POWER_OK_AUX_OE), .IRQ(IRQ),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));

    // ==========================================================
    // clock and oscillator; tick period of four clocks keeps the 4096-tick arming short
    initial begin
        CORE_CLK = 1'b0;
        forever #4 CORE_CLK = ~CORE_CLK;
    end
    always @(posedge CORE_CLK) begin
        tdiv <= tdiv + 2'h1;
        if (tdiv[0]) OSC_TICK <= ~OSC_TICK;
    end

    // ==========================================================
    // helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge CORE_CLK);
    endtask

    // request held from setup until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge CORE_CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        @(posedge CORE_CLK);
        while (PREADY !== 1'b1) @(posedge CORE_CLK);
        rdata = PRDATA;
        rerr = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic do_reset(input logic [1:0] s);
        @(posedge CORE_CLK);
        RST_N <= 1'b0;
        BLANK_TIME_STRAP <= s;
        {ENABLE_MAIN, ENABLE_AUX, OVER_TEMP, CLAMP_LEVEL_MAIN, CLAMP_LEVEL_AUX} <= 5'h00;
        {OVERVOLTAGE_TRIP_MAIN, OVERVOLTAGE_TRIP_AUX} <= 2'h0;
        {UNDERVOLTAGE_TRIP_MAIN, UNDERVOLTAGE_TRIP_AUX, IN_WINDOW_MAIN, IN_WINDOW_AUX} <= 4'h0;
        cyc(3);
        RST_N <= 1'b1;
        cyc(60);
    endtask

    // count cycles of forced pwm and of released main power-ok
    task automatic count(input int n);
        repeat (n) begin
            @(negedge CORE_CLK);
            nf += int'(FORCED_PWM === 1'b1);
            nb += int'(POWER_OK_MAIN_OE === 1'b0);
            @(posedge CORE_CLK);
        end
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset();
        do_reset(2'h2);
        @(negedge CORE_CLK);
        check({POWER_OK_MAIN_OE, POWER_OK_AUX_OE, POWER_OK_MAIN_O, POWER_OK_AUX_O, IRQ, FORCED_PWM},
              6'h30);
        check(DRIVE_MAIN.high_side_gate_off, 1'b1);
        apb(1'b1, `OFS_STATE, 32'hFFFFFFFF);
        apb(1'b0, `OFS_STATE, 32'h0);
        check(rdata, 32'h00000400);
        apb(1'b1, `OFS_MASK, 32'hFFFFFFFF);
        apb(1'b0, `OFS_MASK, 32'h0);
        check(rdata, 32'h0000007F);
        apb(1'b0, 12'h00C, 32'h0);
        check(rerr, 1'b1);
        check(rdata, 32'h00000000);
        $display("test reset done");
    endtask

    task automatic t_ov();
        do_reset(2'h2);
        apb(1'b1, `OFS_MASK, 32'h0000007F);
        ENABLE_MAIN <= 1'b1;
        ENABLE_AUX <= 1'b1;
        cyc(6);
        OVERVOLTAGE_TRIP_AUX <= 1'b1;
        cyc(5);
        @(negedge CORE_CLK);
        check({DRIVE_MAIN.pwm_run, DRIVE_MAIN.high_side_gate_off, DRIVE_MAIN.low_side_gate_on}, 3'h3);
        check({DRIVE_AUX.pwm_run, DRIVE_AUX.high_side_gate_off, DRIVE_AUX.low_side_gate_on}, 3'h3);
        check({POWER_OK_MAIN_OE, POWER_OK_AUX_OE, IRQ}, 3'h7);
        apb(1'b0, `OFS_STATUS, 32'h0);
        check(rdata, 32'h00000002);
        @(negedge CORE_CLK);
        check(IRQ, 1'b0);
        apb(1'b0, `OFS_STATE, 32'h0);
        check(rdata[2:0], 3'h3);
        @(posedge CORE_CLK);
        OVERVOLTAGE_TRIP_AUX <= 1'b0;
        ENABLE_AUX <= 1'b0;
        cyc(6);
        apb(1'b0, `OFS_STATE, 32'h0);
        check(rdata[0], 1'b0);
        apb(1'b0, `OFS_STATUS, 32'h0);
        check(rdata, 32'h00000040);
        $display("test overvoltage done");
    endtask

    task automatic t_uv();
        do_reset(2'h2);
        ENABLE_MAIN <= 1'b1;
        IN_WINDOW_MAIN <= 1'b1;
        UNDERVOLTAGE_TRIP_MAIN <= 1'b1;
        cyc(2200);
        @(negedge CORE_CLK);
        check({POWER_OK_MAIN_OE, POWER_OK_AUX_OE}, 2'h1);
        @(posedge CORE_CLK);
        IN_WINDOW_MAIN <= 1'b0;
        cyc(5);
        @(negedge CORE_CLK);
        check(POWER_OK_MAIN_OE, 1'b1);
        cyc(14000);
        apb(1'b0, `OFS_STATE, 32'h0);
        check(rdata[0], 1'b0);
        cyc(400);
        apb(1'b0, `OFS_STATE, 32'h0);
        check(rdata[2:0], 3'h5);
        @(negedge CORE_CLK);
        check({DRIVE_MAIN.pwm_run, DRIVE_MAIN.low_side_gate_off, DRIVE_MAIN.discharge}, 3'h3);
        check({DRIVE_AUX.pwm_run, DRIVE_AUX.discharge, POWER_OK_MAIN_OE}, 3'h3);
        @(posedge CORE_CLK);
        CLAMP_LEVEL_MAIN <= 1'b1;
        cyc(5);
        @(negedge CORE_CLK);
        check({DRIVE_MAIN.low_side_gate_on, DRIVE_MAIN.discharge}, 2'h2);
        $display("test undervoltage done");
    endtask

    task automatic t_ot();
        do_reset(2'h2);
        ENABLE_AUX <= 1'b1;
        cyc(6);
        OVER_TEMP <= 1'b1;
        cyc(5);
        @(negedge CORE_CLK);
        check({DRIVE_AUX.pwm_run, DRIVE_AUX.discharge, POWER_OK_AUX_OE}, 3'h3);
        @(posedge CORE_CLK);
        ENABLE_AUX <= 1'b0;
        cyc(6);
        ENABLE_AUX <= 1'b1;
        cyc(6);
        apb(1'b0, `OFS_STATE, 32'h0);
        check(rdata[2:0], 3'h7);
        @(posedge CORE_CLK);
        OVER_TEMP <= 1'b0;
        cyc(6);
        ENABLE_AUX <= 1'b0;
        cyc(6);
        apb(1'b0, `OFS_STATUS, 32'h0);
        check(rdata, 32'h00000050);
        $display("test thermal done");
    endtask

    task automatic t_vsel();
        logic [14:0] fp;
        for (int s = 0; s < 4; s++) begin
            do_reset(2'(s));
            fp = (s == 3) ? BL : ((s == 1) ? BS : BM);
            ENABLE_MAIN <= 1'b1;
            ENABLE_AUX <= 1'b1;
            cyc(6);
            nf = 0;
            nb = 0;
            VSEL_BIT0 <= ~VSEL_BIT0;
            count(60);
            check(32'(nf), 32'(fp));
            check(32'(nb), (s == 0) ? 32'h0 : 32'(fp));
            if (s == 0) begin
                OVERVOLTAGE_TRIP_MAIN <= 1'b1;
                cyc(6);
                apb(1'b0, `OFS_STATE, 32'h0);
                check(rdata[0], 1'b1);
            end
        end
        // a second edge mid-period restarts the full count
        nf = 0;
        VSEL_BIT1 <= ~VSEL_BIT1;
        count(15);
        VSEL_BIT0 <= ~VSEL_BIT0;
        count(80);
        check(32'(nf), 32'(BL) + 32'd15);
        VSEL_BIT0 <= ~VSEL_BIT0;
        cyc(6);
        OVERVOLTAGE_TRIP_MAIN <= 1'b1;
        cyc(4);
        OVERVOLTAGE_TRIP_MAIN <= 1'b0;
        cyc(10);
        apb(1'b0, `OFS_STATE, 32'h0);
        check(rdata[0], 1'b0);
        @(posedge CORE_CLK);
        VSEL_BIT0 <= ~VSEL_BIT0;
        cyc(6);
        OVERVOLTAGE_TRIP_AUX <= 1'b1;
        cyc(6);
        apb(1'b0, `OFS_STATE, 32'h0);
        check(rdata[0], 1'b1);
        $display("test select blanking done");
    endtask

    // ==========================================================
    // verdict and main sequence
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        {RST_N, ENABLE_MAIN, ENABLE_AUX, OVER_TEMP, OSC_TICK, VSEL_BIT0, VSEL_BIT1} = 7'h00;
        {OVERVOLTAGE_TRIP_MAIN, OVERVOLTAGE_TRIP_AUX, UNDERVOLTAGE_TRIP_MAIN} = 3'h0;
        {UNDERVOLTAGE_TRIP_AUX, IN_WINDOW_MAIN, IN_WINDOW_AUX} = 3'h0;
        {CLAMP_LEVEL_MAIN, CLAMP_LEVEL_AUX, PSEL, PENABLE, PWRITE} = 5'h00;
        BLANK_TIME_STRAP = 2'h2;
        PADDR = 12'h000;
        PWDATA = 32'h0;
        tdiv = 2'h0;
        n_fail = 0;
        num_checks = 0;
        t_reset();
        t_ov();
        t_uv();
        t_ot();
        t_vsel();
        print_verdict();
    end

    // the whole run needs roughly 18k cycles; over five times that means a hang
    initial begin
        repeat (100000) @(posedge CORE_CLK);
        n_fail++;
        print_verdict();
    end
endmodule
